// ---- hw/vwm_monitor.sv ----
// Purpose: Speed window and threshold monitor
// Assumes: Speeds in user units per second; ms_tick once per ms
// Notes:   All inputs come from logic on clk_sys; only rst_b is synchronised
//
// What this block does
// - Entry 0x606E/0 is a read/write 16-bit settle time, zero after reset.
// - Bit 10 rises only after the speed error stayed in the window longer than the settle time.
// - Bit 10 falls unless in-window and time-elapsed both hold.
// - Settle times 0 to 65535 are taken, in milliseconds.
// - The window is a symmetric band around the commanded speed in user units per second.
// - Settle time writes also go to drive parameter 1277, data set 5, volatile only.
// - An entry written before a save command is stored in non-volatile memory.
// - At power-up each saved entry is restored and overwrites its drive parameter.
// - Entry 0x606F is a read/write speed level 0 to 65535, 100 after reset.
// - Bit 12 falls once the absolute speed stayed above the level for the hold time.
// - Bit 12 rises at once when the absolute speed falls below the level.
// - Entry 0x6070 is a read/write hold time 0 to 65535 ms, zero after reset.
// - Level writes go to drive parameter 1278 and hold time writes to 1279, volatile only.
// - Flags are evaluated only in speed profile mode of a motion-control configuration.
// - Speeds are in user units set by the gear ratio and feed constant entries.
// - With a window width of zero the speed must match the command exactly.
module vwm_monitor (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // Dictionary access
  input  wire logic                obj_req,
  input  wire logic                obj_wr,
  input  wire logic [15:0]         obj_index,
  input  wire logic [7:0]          obj_subidx,
  input  wire logic [15:0]         obj_wdata,
  output logic                     obj_ack,
  output logic                     obj_abort,
  output logic [15:0]              obj_rdata,
  // Save command
  input  wire logic                save_req,
  // Drive mode and speeds
  input  wire logic                motion_cfg,
  input  wire logic                speed_profile_mode,
  input  wire logic signed [31:0]  cmd_speed,
  input  wire logic signed [31:0]  act_speed,
  input  wire logic [15:0]         window_width,
  input  wire logic                ms_tick,
  // Status word flags
  output logic                     target_reached,
  output logic                     speed_low,
  // Drive parameter mirror
  output logic                     drv_par_wr,
  output logic [10:0]              drv_par_num,
  output logic [2:0]               drv_par_set,
  output logic [15:0]              drv_par_data,
  // Non-volatile memory
  output logic                     nv_rd_req,
  output logic [1:0]               nv_rd_sel,
  input  wire logic                nv_rd_valid,
  input  wire logic                nv_rd_present,
  input  wire logic [15:0]         nv_rd_data,
  output logic                     nv_wr_req,
  output logic [1:0]               nv_wr_sel,
  output logic [15:0]              nv_wr_data,
  input  wire logic                nv_wr_ready
);
  import vwm_pkg::*;

  logic               rst_meta_n;
  logic               rst_n;
  logic [15:0]        speed_settle_time;
  logic [15:0]        speed_limit_level;
  logic [15:0]        speed_limit_hold_time;
  logic               sel_hit;
  logic [1:0]         sel_req;
  logic               wr_ok;
  logic               store_busy;
  logic               ld_valid;
  logic [1:0]         ld_sel;
  logic [15:0]        ld_data;
  logic               active;
  logic signed [32:0] speed_err;
  logic [32:0]        err_abs;
  logic [31:0]        act_abs;
  logic               in_window;
  logic               above_level;
  logic               below_level;
  logic               settle_held;
  logic               above_held;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: only sub-index 0 exists
  always_comb
  begin
    sel_hit = 1'b1;
    sel_req = VWM_SEL_SETTLE;
    if (obj_subidx != VWM_SUBIDX)
      sel_hit = 1'b0;
    else if (obj_index == VWM_IDX_SETTLE_TIME)
      sel_req = VWM_SEL_SETTLE;
    else if (obj_index == VWM_IDX_LIMIT_LEVEL)
      sel_req = VWM_SEL_LEVEL;
    else if (obj_index == VWM_IDX_LIMIT_HOLD_TIME)
      sel_req = VWM_SEL_HOLD;
    else
      sel_hit = 1'b0;
  end

  // Refused during restore so a load cannot overwrite a write
  assign wr_ok = obj_req && obj_wr && sel_hit && !store_busy;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      obj_ack   <= 1'b0;
      obj_abort <= 1'b0;
      obj_rdata <= 16'h0000;
    end
    else
    begin
      obj_ack   <= obj_req;
      obj_abort <= obj_req && (!sel_hit || store_busy);
      if (obj_req && !obj_wr && sel_hit && !store_busy)
      begin
        case (sel_req)
          VWM_SEL_SETTLE: obj_rdata <= speed_settle_time;
          VWM_SEL_LEVEL:  obj_rdata <= speed_limit_level;
          default:        obj_rdata <= speed_limit_hold_time;
        endcase
      end
      else
        obj_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entries: full 16-bit range taken without clipping
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_settle_time     <= VWM_RST_SETTLE_TIME;
      speed_limit_level     <= VWM_RST_LIMIT_LEVEL;
      speed_limit_hold_time <= VWM_RST_LIMIT_HOLD_TIME;
    end
    else if (ld_valid)
    begin
      case (ld_sel)
        VWM_SEL_SETTLE: speed_settle_time     <= ld_data;
        VWM_SEL_LEVEL:  speed_limit_level     <= ld_data;
        default:        speed_limit_hold_time <= ld_data;
      endcase
    end
    else if (wr_ok)
    begin
      case (sel_req)
        VWM_SEL_SETTLE: speed_settle_time     <= obj_wdata;
        VWM_SEL_LEVEL:  speed_limit_level     <= obj_wdata;
        default:        speed_limit_hold_time <= obj_wdata;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive parameter mirror: host writes and restored values
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drv_par_wr   <= 1'b0;
      drv_par_num  <= VWM_PAR_SETTLE_TIME;
      drv_par_set  <= VWM_PAR_DATA_SET;
      drv_par_data <= 16'h0000;
    end
    else
    begin
      drv_par_wr  <= ld_valid || wr_ok;
      drv_par_set <= VWM_PAR_DATA_SET;
      if (ld_valid || wr_ok)
      begin
        drv_par_data <= ld_valid ? ld_data : obj_wdata;
        case (ld_valid ? ld_sel : sel_req)
          VWM_SEL_SETTLE: drv_par_num <= VWM_PAR_SETTLE_TIME;
          VWM_SEL_LEVEL:  drv_par_num <= VWM_PAR_LIMIT_LEVEL;
          default:        drv_par_num <= VWM_PAR_LIMIT_HOLD_TIME;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Save and restore
  vwm_param_store u_store (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .wr_pulse      (wr_ok),
    .wr_sel        (sel_req),
    .save_req      (save_req),
    .settle_val    (speed_settle_time),
    .level_val     (speed_limit_level),
    .hold_val      (speed_limit_hold_time),
    .busy          (store_busy),
    .ld_valid      (ld_valid),
    .ld_sel        (ld_sel),
    .ld_data       (ld_data),
    .nv_rd_req     (nv_rd_req),
    .nv_rd_sel     (nv_rd_sel),
    .nv_rd_valid   (nv_rd_valid),
    .nv_rd_present (nv_rd_present),
    .nv_rd_data    (nv_rd_data),
    .nv_wr_req     (nv_wr_req),
    .nv_wr_sel     (nv_wr_sel),
    .nv_wr_data    (nv_wr_data),
    .nv_wr_ready   (nv_wr_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Speed comparisons; scaling to user units is done upstream
  assign active    = motion_cfg && speed_profile_mode;
  assign speed_err = 33'(cmd_speed) - 33'(act_speed);
  assign err_abs   = speed_err[32] ? 33'(-speed_err) : 33'(speed_err);
  assign act_abs   = act_speed[31] ? 32'(-act_speed) : 32'(act_speed);

  always_comb
  begin
    if (window_width == 16'h0000)
      in_window = (err_abs == 33'h000000000);
    else
      in_window = (err_abs < {17'h00000, window_width});
  end

  // At the level bit 12 keeps its value
  assign above_level = act_abs > {16'h0000, speed_limit_level};
  assign below_level = act_abs < {16'h0000, speed_limit_level};

  ////////////////////////////////////////////////////////////////////////////
  // Persistence timers; leaving the mode also restarts them
  vwm_persist_timer #(
    .STRICT (1'b1)
  ) u_settle_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cond    (active && in_window),
    .ms_tick (ms_tick),
    .limit   (speed_settle_time),
    .held    (settle_held)
  );

  vwm_persist_timer #(
    .STRICT (1'b0)
  ) u_level_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cond    (active && above_level),
    .ms_tick (ms_tick),
    .limit   (speed_limit_hold_time),
    .held    (above_held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      target_reached <= 1'b0;
    else if (!active)
      target_reached <= 1'b0;
    else
      target_reached <= settle_held;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      speed_low <= 1'b0;
    else if (!active)
      speed_low <= 1'b0;
    else if (below_level)
      speed_low <= 1'b1;
    else if (above_held)
      speed_low <= 1'b0;
  end

endmodule

// ---- hw/vwm_param_store.sv ----
// Purpose: Save and power-up restore of the entries
// Assumes: Memory answers reads with nv_rd_valid, takes writes on nv_wr_ready
// Notes:   Only entries written since their last save are stored
module vwm_param_store (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Entry writes and save command
  input  wire logic        wr_pulse,
  input  wire logic [1:0]  wr_sel,
  input  wire logic        save_req,
  input  wire logic [15:0] settle_val,
  input  wire logic [15:0] level_val,
  input  wire logic [15:0] hold_val,
  // Restore toward the entries
  output logic             busy,
  output logic             ld_valid,
  output logic [1:0]       ld_sel,
  output logic [15:0]      ld_data,
  // Non-volatile memory
  output logic             nv_rd_req,
  output logic [1:0]       nv_rd_sel,
  input  wire logic        nv_rd_valid,
  input  wire logic        nv_rd_present,
  input  wire logic [15:0] nv_rd_data,
  output logic             nv_wr_req,
  output logic [1:0]       nv_wr_sel,
  output logic [15:0]      nv_wr_data,
  input  wire logic        nv_wr_ready
);
  import vwm_pkg::*;

  vwm_store_state_t state;
  logic [1:0]                  sel;
  logic                        save_pend;
  logic [VWM_N_ENTRY-1:0]      dirty;
  logic [VWM_N_ENTRY-1:0]      dirty_clr;
  logic [15:0]                 cur_val;

  always_comb
  begin
    case (sel)
      VWM_SEL_SETTLE: cur_val = settle_val;
      VWM_SEL_LEVEL:  cur_val = level_val;
      default:        cur_val = hold_val;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dirty flags: a write during its own store wins
  genvar gi;
  generate
    for (gi = 0; gi < VWM_N_ENTRY; gi++)
    begin : g_dirty
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          dirty[gi] <= 1'b0;
        else if (wr_pulse && wr_sel == 2'(gi))
          dirty[gi] <= 1'b1;
        else if (dirty_clr[gi])
          dirty[gi] <= 1'b0;
      end
      assign dirty_clr[gi] = (state == VWM_ST_SAVE) && !nv_wr_req && sel == 2'(gi);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      save_pend <= 1'b0;
    else if (save_req)
      save_pend <= 1'b1;
    else if (state == VWM_ST_IDLE)
      save_pend <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restore at power-up, then serve save commands
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= VWM_ST_RESTORE_REQ;
      sel        <= VWM_SEL_SETTLE;
      busy       <= 1'b1;
      ld_valid   <= 1'b0;
      ld_sel     <= VWM_SEL_SETTLE;
      ld_data    <= 16'h0000;
      nv_rd_req  <= 1'b0;
      nv_rd_sel  <= VWM_SEL_SETTLE;
      nv_wr_req  <= 1'b0;
      nv_wr_sel  <= VWM_SEL_SETTLE;
      nv_wr_data <= 16'h0000;
    end
    else
    begin
      ld_valid <= 1'b0;
      case (state)
        VWM_ST_RESTORE_REQ:
        begin
          nv_rd_req <= 1'b1;
          nv_rd_sel <= sel;
          state     <= VWM_ST_RESTORE_WAIT;
        end
        VWM_ST_RESTORE_WAIT:
        begin
          nv_rd_req <= 1'b0;
          if (nv_rd_valid)
          begin
            ld_valid <= nv_rd_present;
            ld_sel   <= sel;
            ld_data  <= nv_rd_data;
            if (sel == VWM_SEL_LAST)
            begin
              sel   <= VWM_SEL_SETTLE;
              state <= VWM_ST_IDLE;
            end
            else
            begin
              sel   <= sel + 2'h1;
              state <= VWM_ST_RESTORE_REQ;
            end
          end
        end
        VWM_ST_IDLE:
        begin
          sel  <= VWM_SEL_SETTLE;
          busy <= 1'b0;
          if (save_pend)
            state <= VWM_ST_SAVE;
        end
        VWM_ST_SAVE:
        begin
          if (!nv_wr_req && dirty[sel])
          begin
            nv_wr_req  <= 1'b1;
            nv_wr_sel  <= sel;
            nv_wr_data <= cur_val;
          end
          else if (!nv_wr_req || nv_wr_ready)
          begin
            nv_wr_req <= 1'b0;
            if (sel == VWM_SEL_LAST)
              state <= VWM_ST_IDLE;
            else
              sel <= sel + 2'h1;
          end
        end
        default:
          state <= VWM_ST_IDLE;
      endcase
    end
  end

endmodule

// ---- hw/vwm_persist_timer.sv ----
// Purpose: Millisecond persistence timer
// Assumes: ms_tick pulses once per millisecond
// Notes:   STRICT selects "longer than" (1) or "at least" (0) the limit
module vwm_persist_timer #(
  parameter bit STRICT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Condition and timing
  input  wire logic        cond,
  input  wire logic        ms_tick,
  input  wire logic [15:0] limit,
  // Result
  output logic             held
);
  import vwm_pkg::*;

  logic [16:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Restart on any break; saturate so a long hold never wraps back
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 17'h00000;
    else if (!cond)
      cnt <= 17'h00000;
    else if (ms_tick && cnt != VWM_CNT_MAX)
      cnt <= cnt + 17'h00001;
  end

  always_comb
  begin
    if (STRICT)
      held = cond && (cnt > {1'b0, limit});
    else
      held = cond && (cnt >= {1'b0, limit});
  end

endmodule

// ---- shared/vwm_pkg.sv ----
// Purpose: Constants and types of the speed window monitor
// Assumes: 16-bit dictionary entries, sub-index 0 only
// Notes:   Drive parameter numbers in data set 5
package vwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Entry indices
  localparam logic [15:0] VWM_IDX_SETTLE_TIME     = 16'h606E;
  localparam logic [15:0] VWM_IDX_LIMIT_LEVEL     = 16'h606F;
  localparam logic [15:0] VWM_IDX_LIMIT_HOLD_TIME = 16'h6070;
  localparam logic [7:0]  VWM_SUBIDX              = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Entry reset values
  localparam logic [15:0] VWM_RST_SETTLE_TIME     = 16'h0000;
  localparam logic [15:0] VWM_RST_LIMIT_LEVEL     = 16'h0064;
  localparam logic [15:0] VWM_RST_LIMIT_HOLD_TIME = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Status word bit positions
  localparam int VWM_BIT_TARGET_REACHED = 10;
  localparam int VWM_BIT_SPEED_LOW      = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Drive parameter mirror
  localparam logic [10:0] VWM_PAR_SETTLE_TIME     = 11'h4FD;
  localparam logic [10:0] VWM_PAR_LIMIT_LEVEL     = 11'h4FE;
  localparam logic [10:0] VWM_PAR_LIMIT_HOLD_TIME = 11'h4FF;
  localparam logic [2:0]  VWM_PAR_DATA_SET        = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Entry selectors
  localparam int          VWM_N_ENTRY     = 3;
  localparam logic [1:0]  VWM_SEL_SETTLE  = 2'h0;
  localparam logic [1:0]  VWM_SEL_LEVEL   = 2'h1;
  localparam logic [1:0]  VWM_SEL_HOLD    = 2'h2;
  localparam logic [1:0]  VWM_SEL_LAST    = 2'h2;

  // Counter saturates one past the largest time
  localparam logic [16:0] VWM_CNT_MAX     = 17'h10000;

  typedef enum {
    VWM_ST_RESTORE_REQ,
    VWM_ST_RESTORE_WAIT,
    VWM_ST_IDLE,
    VWM_ST_SAVE
  } vwm_store_state_t;

endpackage

// ---- testbench/tb.sv ----
// Purpose: Bench for the speed window monitor
// Assumes: Bench drives ms_tick
// Notes:   Second reset checks restore
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vwm_pkg::*;
  logic               clk_sys = 1'b0, rst_b = 1'b0, obj_req = 1'b0, obj_wr = 1'b0, save_req = 1'b0;
  logic               motion_cfg = 1'b0, speed_profile_mode = 1'b0, ms_tick = 1'b0, slow = 1'b0;
  logic [15:0]        obj_index = 16'h0, obj_wdata = 16'h0, window_width = 16'h0;
  logic [7:0]         obj_subidx = 8'h00;
  logic signed [31:0] cmd_speed = 32'sh0, act_speed = 32'sh0, a_in, a_out;
  logic               obj_ack, obj_abort, target_reached, speed_low, drv_par_wr, nv_rd_req, nv_wr_req;
  logic               nv_rd_valid, nv_rd_present, nv_wr_ready, g_ab, g_pw;
  logic [15:0]        obj_rdata, drv_par_data, nv_rd_data, nv_wr_data, g_rd, g_pd, t_set, w, lvl, hld;
  logic [10:0]        drv_par_num, g_pn;
  logic [2:0]         drv_par_set;
  logic [1:0]         nv_rd_sel, nv_wr_sel;
  int                 err_count = 0, n_checks = 0, n_par = 0, n_nvw = 0;
  integer             seed = 55;
  vwm_monitor dut_u (.*);
  vwm_nv_model nv_u (.*);
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (drv_par_wr === 1'b1) n_par++;
    if (nv_wr_req === 1'b1 && nv_wr_ready === 1'b1) n_nvw++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      ms_tick = 1'b1;
      cyc(1);
      ms_tick = 1'b0;
      cyc(1);
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] d);
    cyc(1);
    obj_req = 1'b1;
    obj_wr = wr;
    obj_index = idx;
    obj_subidx = sub;
    obj_wdata = d;
    cyc(1);
    obj_req = 1'b0;
    chk("ack", 16'h1, 16'(obj_ack));
    g_ab = obj_abort;
    g_rd = obj_rdata;
    g_pw = drv_par_wr;
    g_pn = drv_par_num;
    g_pd = drv_par_data;
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] e);
    xfer(1'b0, idx, 8'h00, 16'h0);
    chk("read", e, g_rd);
  endtask
  task automatic wr_chk(input logic [15:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, 8'h00, d);
    chk("abort", 16'h0, 16'(g_ab));
    chk("par strobe", 16'h1, 16'(g_pw));
    chk("par num", 16'(VWM_PAR_SETTLE_TIME + 11'(idx - VWM_IDX_SETTLE_TIME)), 16'(g_pn));
    chk("par data", d, g_pd);
    rd_chk(idx, d);
  endtask
  // Polls until restore ends
  task automatic boot();
    rst_b = 1'b0;
    cyc(12);
    rst_b = 1'b1;
    n_par = 0;
    g_ab = 1'b1;
    cyc(3);
    for (int k = 0; k < 40 && g_ab !== 1'b0; k++)
      xfer(1'b0, VWM_IDX_SETTLE_TIME, 8'h00, 16'h0);
    if (g_ab !== 1'b0)
    begin
      chk("restore end", 16'h0, 16'h1);
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    boot();
    chk("loads", 16'h0, 16'(n_par));
    rd_chk(VWM_IDX_SETTLE_TIME, 16'h0000);
    rd_chk(VWM_IDX_LIMIT_LEVEL, 16'h0064);
    rd_chk(VWM_IDX_LIMIT_HOLD_TIME, 16'h0000);
    xfer(1'b0, 16'h6071, 8'h00, 16'h0);
    chk("bad index", 16'h1, 16'(g_ab));
    xfer(1'b1, VWM_IDX_LIMIT_LEVEL, 8'h01, 16'h1234);
    chk("bad subindex", 16'h1, 16'(g_ab));
    rd_chk(VWM_IDX_LIMIT_LEVEL, 16'h0064);
    wr_chk(VWM_IDX_SETTLE_TIME, 16'hFFFF);
    wr_chk(VWM_IDX_LIMIT_HOLD_TIME, 16'hFFFF);
    {motion_cfg, speed_profile_mode} = 2'h3;
    for (int r = 0; r < 4; r++)
    begin
      t_set = (r == 0) ? 16'h0 : 16'($unsigned($random(seed)) % 5);
      w = (r == 0) ? 16'h0 : 16'($unsigned($random(seed)) % 200 + 1);
      wr_chk(VWM_IDX_SETTLE_TIME, t_set);
      window_width = w;
      cmd_speed = $random(seed) % 100000;
      a_out = cmd_speed + 32'(w) + 32'(w == 16'h0);
      a_in = (w == 16'h0) ? cmd_speed : (r[0] ? cmd_speed - 32'(w) + 1 : cmd_speed + 32'(w) - 1);
      act_speed = a_in;
      tick(t_set);
      act_speed = a_out;
      cyc(2);
      chk("band edge", 16'h0, 16'(target_reached));
      act_speed = a_in;
      tick(t_set);
      cyc(3);
      chk("early reach", 16'h0, 16'(target_reached));
      tick(1);
      cyc(3);
      chk("reach", 16'h1, 16'(target_reached));
      {motion_cfg, speed_profile_mode} = 2'(r);
      cyc(3);
      chk("mode", 16'(r == 3), 16'(target_reached));
      {motion_cfg, speed_profile_mode} = 2'h3;
      act_speed = a_out;
      cyc(3);
      chk("leave band", 16'h0, 16'(target_reached));
    end
    for (int r = 0; r < 2; r++)
    begin
      lvl = 16'($unsigned($random(seed)) % 1000 + 1);
      hld = (r == 0) ? 16'h0 : 16'($unsigned($random(seed)) % 4 + 2);
      wr_chk(VWM_IDX_LIMIT_LEVEL, lvl);
      wr_chk(VWM_IDX_LIMIT_HOLD_TIME, hld);
      act_speed = 32'(lvl) - 1;
      cyc(3);
      chk("low set", 16'h1, 16'(speed_low));
      act_speed = -32'sd1 - 32'(lvl);
      if (hld != 16'h0)
      begin
        tick(hld - 1);
        cyc(3);
        chk("low held", 16'h1, 16'(speed_low));
        tick(1);
      end
      cyc(3);
      chk("low clear", 16'h0, 16'(speed_low));
      act_speed = 32'(lvl);
      cyc(3);
      chk("low at level", 16'h0, 16'(speed_low));
    end
    slow = 1'b1;
    t_set = 16'($random(seed));
    wr_chk(VWM_IDX_SETTLE_TIME, t_set);
    n_nvw = 0;
    save_req = 1'b1;
    cyc(1);
    save_req = 1'b0;
    for (int k = 0; k < 200 && n_nvw < 3; k++)
      cyc(1);
    chk("saved", 16'h3, 16'(n_nvw));
    wr_chk(VWM_IDX_LIMIT_LEVEL, ~lvl);
    boot();
    chk("loads", 16'h3, 16'(n_par));
    rd_chk(VWM_IDX_SETTLE_TIME, t_set);
    rd_chk(VWM_IDX_LIMIT_LEVEL, lvl);
    rd_chk(VWM_IDX_LIMIT_HOLD_TIME, hld);
    conclude();
  end
endmodule

// ---- testbench/vwm_checker.sv ----
// Purpose: Port assertions of the monitor
// Assumes: One clock
// Notes:   Band recomputed from ports
module vwm_checker (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // Dictionary access
  input wire logic               obj_req,
  input wire logic               obj_wr,
  input wire logic [15:0]        obj_index,
  input wire logic [7:0]         obj_subidx,
  input wire logic               obj_ack,
  input wire logic               obj_abort,
  input wire logic [15:0]        obj_rdata,
  // Mode, speeds and flags
  input wire logic               motion_cfg,
  input wire logic               speed_profile_mode,
  input wire logic signed [31:0] cmd_speed,
  input wire logic signed [31:0] act_speed,
  input wire logic [15:0]        window_width,
  input wire logic               target_reached,
  input wire logic               speed_low,
  // Mirror and memory
  input wire logic               drv_par_wr,
  input wire logic [10:0]        drv_par_num,
  input wire logic [2:0]         drv_par_set,
  input wire logic               nv_wr_req,
  input wire logic [1:0]         nv_wr_sel,
  input wire logic               nv_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import vwm_pkg::*;
  logic signed [32:0] diff;
  logic signed [32:0] mag;
  logic               in_win;
  assign diff = cmd_speed - act_speed;
  assign mag = (diff < 0) ? -diff : diff;
  assign in_win = (window_width == 16'h0) ? (diff == 0) : (mag < $signed({17'h0, window_width}));
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr(logic [15:0] idx);
    obj_req && obj_wr && obj_index == idx && obj_subidx == 8'h00;
  endsequence
  // Abort covers writes during restore
  sequence s_mirror(logic [10:0] num);
    obj_abort || (drv_par_wr && drv_par_num == num && drv_par_set == VWM_PAR_DATA_SET);
  endsequence
  property p_ack; obj_req |=> obj_ack; endproperty
  property p_refuse; obj_req && obj_subidx != 8'h00 |=> obj_abort && obj_rdata == 16'h0; endproperty
  property p_mir_time; s_wr(VWM_IDX_SETTLE_TIME) |=> s_mirror(VWM_PAR_SETTLE_TIME); endproperty
  property p_mir_level; s_wr(VWM_IDX_LIMIT_LEVEL) |=> s_mirror(VWM_PAR_LIMIT_LEVEL); endproperty
  property p_mode; !(motion_cfg && speed_profile_mode) |=> !target_reached && !speed_low; endproperty
  property p_tr_rise; $rose(target_reached) |-> $past(in_win) && $past(in_win, 2); endproperty
  property p_tr_fall; !in_win |=> !target_reached; endproperty
  property p_nv_hold; nv_wr_req && !nv_wr_ready |=> nv_wr_req && $stable(nv_wr_sel); endproperty
  a_ack: assert property (p_ack) else $error("answer missing");
  a_refuse: assert property (p_refuse) else $error("bad subindex not refused");
  a_mir_time: assert property (p_mir_time) else $error("settle time not mirrored");
  a_mir_level: assert property (p_mir_level) else $error("level not mirrored");
  a_mode: assert property (p_mode) else $error("flag outside speed mode");
  a_tr_rise: assert property (p_tr_rise) else $error("reached outside band");
  a_tr_fall: assert property (p_tr_fall) else $error("reached kept outside band");
  a_nv_hold: assert property (p_nv_hold) else $error("memory write dropped");
endmodule

bind vwm_monitor vwm_checker chk_u (.*);

// ---- testbench/vwm_nv_model.sv ----
// Purpose: Non-volatile memory model
// Assumes: Contents survive resets
// Notes:   slow adds stalls
module vwm_nv_model (
  // Clock and stall control
  input  wire logic        clk_sys,
  input  wire logic        slow,
  // Read side
  input  wire logic        nv_rd_req,
  input  wire logic [1:0]  nv_rd_sel,
  output logic             nv_rd_valid,
  output logic             nv_rd_present,
  output logic [15:0]      nv_rd_data,
  // Write side
  input  wire logic        nv_wr_req,
  input  wire logic [1:0]  nv_wr_sel,
  input  wire logic [15:0] nv_wr_data,
  output logic             nv_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [3];
  logic [2:0]  pres;
  logic [1:0]  sel;
  logic [2:0]  dly;
  logic        pend;
  initial
  begin
    {nv_rd_valid, nv_rd_present, nv_rd_data, nv_wr_ready, pres, pend, dly} = '0;
  end
  // Read present and data lines toggle outside answers; valid stays low
  always @(posedge clk_sys)
  begin
    nv_rd_valid <= 1'b0;
    nv_rd_present <= ~nv_rd_present;
    nv_rd_data <= ~nv_rd_data;
    nv_wr_ready <= slow ? ~nv_wr_ready : 1'b1;
    if (nv_rd_req)
    begin
      pend <= 1'b1;
      sel <= nv_rd_sel;
      dly <= slow ? 3'h3 : 3'h0;
    end
    else if (pend && dly != 3'h0)
      dly <= dly - 3'h1;
    else if (pend)
    begin
      pend <= 1'b0;
      nv_rd_valid <= 1'b1;
      nv_rd_present <= pres[sel];
      nv_rd_data <= mem[sel];
    end
    if (nv_wr_req && nv_wr_ready)
    begin
      mem[nv_wr_sel] <= nv_wr_data;
      pres[nv_wr_sel] <= 1'b1;
    end
  end
endmodule
